//--- verilog/ptc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          time clock and trigger control block.
// Assumes: Register indexes are word indexes; byte address is four times the index.
// Notes:   Definitions only.
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH

// ****************************************************************
// Register indexes
// ****************************************************************
`define PTC_IDX_PAGE_SELECT 8'h13
`define PTC_IDX_CTL         8'h14
`define PTC_IDX_TDR         8'h15
`define PTC_IDX_TSTS        8'h17
`define PTC_PAGE_PTP        3'h4

// ****************************************************************
// Control register fields
// ****************************************************************
`define PTC_CTL_SEL_HI      12
`define PTC_CTL_SEL_LO      10
`define PTC_CTL_DISABLE_CMD 9
`define PTC_CTL_ENABLE_CMD  8
`define PTC_CTL_READBACK    7
`define PTC_CTL_TRIG_PROG   6
`define PTC_CTL_SAMPLE      5
`define PTC_CTL_SET         4
`define PTC_CTL_ADJUST      3
`define PTC_CTL_RUN_ON      2
`define PTC_CTL_RUN_OFF     1
`define PTC_CTL_TK_RST      0
`define PTC_CTL_RESET       16'h0000
`define PTC_PAGE_SEL_RESET  3'h0

// ****************************************************************
// Time-data port and timing
// ****************************************************************
`define PTC_WORDS           3'h4
`define PTC_LAST_WORD       3'h3
`define PTC_CLK_MHZ         1000
`define PTC_CLK_RATE_MHZ    50
`define PTC_NS_STEP         (`PTC_CLK_MHZ / `PTC_CLK_RATE_MHZ)
`define PTC_NS_PER_SEC      32'h3b9aca00

`endif

//--- verilog/ptc_pkg.sv
// Purpose: Types shared by the time clock and trigger control modules.
// Assumes: Time value is 32 bits of seconds above 32 bits of nanoseconds.
// Notes:   Mode codes are one-hot.
package ptc_pkg;

  typedef enum logic [3:0] {
    PTC_IDLE   = 4'b0001,
    PTC_CLK_RD = 4'b0010,
    PTC_TRG_RD = 4'b0100,
    PTC_TRG_LD = 4'b1000
  } ptc_mode_e;

  typedef logic [63:0] ptc_time_t;

endpackage

//--- verilog/ptc_clk_if.sv
// Purpose: Command and value path between the control logic and the time clock.
// Assumes: One clock domain.
// Notes:   load and step are one-cycle pulses.
`timescale 1ns/1ps
interface ptc_clk_if;
  import ptc_pkg::*;

  logic      run;
  logic      load;
  logic      step;
  logic      tk_rst;
  ptc_time_t wr_val;
  ptc_time_t now;

  modport ctl (output run, output load, output step, output tk_rst, output wr_val,
               input now);
  modport clk (input run, input load, input step, input tk_rst, input wr_val,
               output now);
endinterface

//--- verilog/ptc_time_clock.sv
// Purpose: Running time clock with load, add-offset and hold-in-reset.
// Assumes: Offsets carry fewer than one second of nanoseconds.
// Notes:   Advances one clock period of nanoseconds per enabled cycle.
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_time_clock
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  ptc_clk_if.clk   tc
);

  typedef struct packed {
    ptc_time_t now;
  } ptc_tclk_s;

  ptc_tclk_s st;
  ptc_tclk_s next_st;

  // Seconds carry once nanoseconds reach a whole second
  function automatic ptc_time_t ptc_add(input ptc_time_t a, input ptc_time_t b);
    logic [32:0] ns_sum;
    logic [31:0] sec_sum;
    ns_sum  = {1'b0, a[31:0]} + {1'b0, b[31:0]};
    sec_sum = a[63:32] + b[63:32];
    if (ns_sum >= {1'b0, `PTC_NS_PER_SEC}) begin
      ns_sum  = ns_sum - {1'b0, `PTC_NS_PER_SEC};
      sec_sum = sec_sum + 32'h0000_0001;
    end
    return {sec_sum, ns_sum[31:0]};
  endfunction

  always_comb begin
    next_st = st;
    if (tc.tk_rst) begin
      next_st.now = '0;
    end else if (tc.load) begin
      next_st.now = tc.wr_val;
    end else if (tc.step) begin
      next_st.now = ptc_add(st.now, tc.wr_val);
    end else if (tc.run) begin
      next_st.now = ptc_add(st.now, 64'(`PTC_NS_STEP));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tc.now = st.now;

  a_clk_load: assert property (@(posedge clk) disable iff (rst)
    ce && tc.load && !tc.tk_rst |=> st.now == $past(tc.wr_val))
    else $error("time clock did not take loaded value");

  a_clk_still: assert property (@(posedge clk) disable iff (rst)
    ce && !tc.run && !tc.load && !tc.step && !tc.tk_rst |=> $stable(st.now))
    else $error("stopped time clock moved");

endmodule

//--- verilog/ptc_ctrl.sv
// Purpose: Control register, time-data port and trigger bank of the time clock.
// Assumes: APB slave, zero wait states while ce is high; pready low freezes access.
// Notes:   Eight triggers, each a 64-bit fire time written as four 16-bit words.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_ctrl
  import ptc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [9:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  trig_out,
  output logic      [7:0]  trig_active,
  output logic             clock_running
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]             page;
    logic [2:0]             trig_idx;
    logic                   run;
    logic                   tk_rst;
    ptc_mode_e              mode;
    logic [2:0]             widx;
    logic [3:0][15:0]       stage;
    ptc_time_t              sample;
    logic [7:0][3:0][15:0]  trg;
    logic [7:0]             act;
    logic [7:0]             outv;
    logic [31:0]            rdata;
    logic                   err;
  } ptc_state_s;

  ptc_state_s st;
  ptc_state_s next_st;

  ptc_clk_if tc ();

  logic [7:0]  idx;
  logic        page_ok;
  logic        hit_pg;
  logic        hit_ctl;
  logic        hit_tdr;
  logic        hit_tsts;
  logic        setup;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        ld_cmd;
  logic        step_cmd;
  logic [15:0] ctl_rd;
  logic [15:0] tdr_rd;

  ptc_time_clock u_clock (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .tc  (tc)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign idx     = paddr[9:2];
  assign page_ok  = (st.page == `PTC_PAGE_PTP);
  assign hit_pg   = (idx == `PTC_IDX_PAGE_SELECT);
  assign hit_ctl  = page_ok && (idx == `PTC_IDX_CTL);
  assign hit_tdr  = page_ok && (idx == `PTC_IDX_TDR);
  assign hit_tsts = page_ok && (idx == `PTC_IDX_TSTS);
  assign setup   = ce && psel && !penable;
  assign acc     = ce && psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;

  assign ctl_rd = {3'h0, st.trig_idx, 3'h0, (st.mode == PTC_TRG_LD), 3'h0,
                   st.run, 1'b0, st.tk_rst};

  always_comb begin
    tdr_rd = 16'h0000;
    if (st.widx < `PTC_WORDS) begin
      if (st.mode == PTC_CLK_RD) begin
        tdr_rd = st.sample[16*st.widx[1:0] +: 16];
      end else if (st.mode == PTC_TRG_RD) begin
        tdr_rd = st.trg[st.trig_idx][st.widx[1:0]];
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st  = st;
    ld_cmd   = 1'b0;
    step_cmd = 1'b0;

    for (int i = 0; i < 8; i++) begin
      if (st.act[i] && (tc.now >= st.trg[i])) begin
        next_st.act[i]  = 1'b0;
        next_st.outv[i] = 1'b1;
      end
    end

    // Read data is caught in the setup phase so prdata comes from a flop
    if (setup) begin
      next_st.err   = !(hit_pg || hit_ctl || hit_tdr || hit_tsts);
      next_st.rdata = '0;
      if (hit_pg) begin
        next_st.rdata[2:0] = st.page;
      end else if (hit_ctl) begin
        next_st.rdata[15:0] = ctl_rd;
      end else if (hit_tdr) begin
        next_st.rdata[15:0] = tdr_rd;
      end else if (hit_tsts) begin
        for (int i = 0; i < 8; i++) begin
          next_st.rdata[2*i] = st.act[i];
        end
      end
    end

    if (rd && hit_tdr && (st.widx < `PTC_WORDS)) begin
      next_st.widx = st.widx + 3'h1;
    end

    if (wr && hit_pg) begin
      next_st.page = pwdata[2:0];
    end

    if (wr && hit_tdr) begin
      case (st.mode)
        PTC_TRG_LD: begin
          next_st.trg[st.trig_idx][st.widx[1:0]] = pwdata[15:0];
          next_st.widx = st.widx + 3'h1;
          if (st.widx == `PTC_LAST_WORD) begin
            next_st.mode = PTC_IDLE;
            next_st.widx = 3'h0;
          end
        end
        PTC_IDLE: begin
          if (st.widx < `PTC_WORDS) begin
            next_st.stage[st.widx[1:0]] = pwdata[15:0];
            next_st.widx = st.widx + 3'h1;
          end
        end
        default: begin
          // A write during a read-out starts a fresh staging sequence
          next_st.mode     = PTC_IDLE;
          next_st.stage[0] = pwdata[15:0];
          next_st.widx     = 3'h1;
        end
      endcase
    end

    if (wr && hit_ctl) begin
      next_st.trig_idx = pwdata[`PTC_CTL_SEL_HI:`PTC_CTL_SEL_LO];
      next_st.tk_rst   = pwdata[`PTC_CTL_TK_RST];
      if (pwdata[`PTC_CTL_RUN_OFF]) begin
        next_st.run = 1'b0;
      end else if (pwdata[`PTC_CTL_RUN_ON]) begin
        next_st.run = 1'b1;
      end
      if (pwdata[`PTC_CTL_SET]) begin
        ld_cmd = 1'b1;
      end else if (pwdata[`PTC_CTL_ADJUST]) begin
        step_cmd = 1'b1;
      end
      if (pwdata[`PTC_CTL_SET] || pwdata[`PTC_CTL_ADJUST]) begin
        next_st.mode = PTC_IDLE;
        next_st.widx = 3'h0;
      end
      if (pwdata[`PTC_CTL_SAMPLE]) begin
        next_st.sample = tc.now;
        next_st.mode   = PTC_CLK_RD;
        next_st.widx   = 3'h0;
      end
      if (pwdata[`PTC_CTL_READBACK]) begin
        next_st.mode = PTC_TRG_RD;
        next_st.widx = 3'h0;
      end
      if (pwdata[`PTC_CTL_TRIG_PROG]) begin
        next_st.act[pwdata[`PTC_CTL_SEL_HI:`PTC_CTL_SEL_LO]] = 1'b0;
        next_st.mode = PTC_TRG_LD;
        next_st.widx = 3'h0;
      end
      if (pwdata[`PTC_CTL_DISABLE_CMD]) begin
        next_st.act[pwdata[`PTC_CTL_SEL_HI:`PTC_CTL_SEL_LO]] = 1'b0;
      end
      if (pwdata[`PTC_CTL_ENABLE_CMD]) begin
        next_st.act[pwdata[`PTC_CTL_SEL_HI:`PTC_CTL_SEL_LO]]  = 1'b1;
        next_st.outv[pwdata[`PTC_CTL_SEL_HI:`PTC_CTL_SEL_LO]] = 1'b0;
        if (next_st.mode == PTC_TRG_LD) begin
          // Counter restarts so a following time value fills from word 0
          next_st.mode = PTC_IDLE;
          next_st.widx = 3'h0;
        end
      end
    end

    // everything but page, the reset bit, read data and the error flag is cleared
    if (next_st.tk_rst) begin
      next_st.trig_idx = 3'h0;
      next_st.run      = 1'b0;
      next_st.mode     = PTC_IDLE;
      next_st.widx     = 3'h0;
      next_st.stage    = '0;
      next_st.sample   = '0;
      next_st.trg      = '0;
      next_st.act      = '0;
      next_st.outv     = '0;
      ld_cmd           = 1'b0;
      step_cmd         = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.mode     <= PTC_IDLE;
      st.page     <= `PTC_PAGE_SEL_RESET;
      st.trig_idx <= 3'(`PTC_CTL_RESET >> `PTC_CTL_SEL_LO);
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tc.run    = st.run;
  assign tc.load   = ld_cmd;
  assign tc.step   = step_cmd;
  assign tc.tk_rst = st.tk_rst;
  assign tc.wr_val = st.stage;

  assign prdata        = st.rdata;
  assign pready        = ce;
  assign pslverr       = st.err;
  assign trig_out      = st.outv;
  assign trig_active   = st.act;
  assign clock_running = st.run;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_page_gate: assert property (@(posedge clk) disable iff (rst)
    wr && (idx == `PTC_IDX_CTL) && !page_ok |=> $stable(st.trig_idx) && $stable(st.tk_rst))
    else $error("control register written outside page four");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    setup && hit_ctl ##1 acc |-> prdata[15:13] == 3'h0 && prdata[9:7] == 3'h0)
    else $error("reserved or self-clearing control bits read nonzero");

  a_idx_write: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && !pwdata[0] |=> st.trig_idx == $past(pwdata[12:10]))
    else $error("trigger index not stored");

  a_dis_clear: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && pwdata[9] && !pwdata[8]
    |=> !st.act[$past(pwdata[12:10])])
    else $error("disable left trigger active");

  a_dis_keeps: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && pwdata[9] && !pwdata[8] && !pwdata[0]
    |=> st.outv[$past(pwdata[12:10])] >= $past(st.outv[pwdata[12:10]]))
    else $error("disable dropped trigger output");

  a_en_arms: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && pwdata[8] && !pwdata[0]
    |=> st.act[$past(pwdata[12:10])] && !trig_out[$past(pwdata[12:10])])
    else $error("enable did not arm trigger");

  a_prog_mode: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && pwdata[6] && !pwdata[8] && !pwdata[0]
    |=> st.mode == PTC_TRG_LD && st.widx == 3'h0 && !st.act[$past(pwdata[12:10])])
    else $error("program command did not start capture");

  a_prog_end: assert property (@(posedge clk) disable iff (rst)
    wr && hit_tdr && st.mode == PTC_TRG_LD && st.widx == 3'h3 && !st.tk_rst
    |=> st.mode == PTC_IDLE && st.widx == 3'h0)
    else $error("programming did not end after last word");

  a_sample_get: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && pwdata[5] && !pwdata[7] && !pwdata[6] && !pwdata[0]
    |=> st.mode == PTC_CLK_RD && st.sample == $past(tc.now))
    else $error("sample did not capture the time");

  a_run_on: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && pwdata[2] && !pwdata[1] && !pwdata[0] |=> clock_running)
    else $error("run-on did not start clock");

  a_run_off: assert property (@(posedge clk) disable iff (rst)
    wr && hit_ctl && pwdata[1] |=> !clock_running)
    else $error("run-off did not stop clock");

  a_tk_hold: assert property (@(posedge clk) disable iff (rst)
    st.tk_rst && !(wr && hit_ctl) |=> st.tk_rst && st.act == 8'h00 && !st.run)
    else $error("timekeeper reset released without a write");

  a_past_end: assert property (@(posedge clk) disable iff (rst)
    setup && hit_tdr && st.widx >= 3'h4 |=> prdata == 32'h0000_0000)
    else $error("time-data port read past end returned data");

endmodule

//--- dv/ptc_clock_trigger_control_tb_top.sv
// Purpose: Self-checking bench for the time clock and trigger control block.
// Assumes: ce stays high except for the stalled first word of each put4; clock stopped for exact reads.
// Notes:   Every APB transfer leaves a note; the monitor checks it at the access edge.
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_clock_trigger_control_tb_top;
  localparam logic [9:0] A_PAGE = {`PTC_IDX_PAGE_SELECT, 2'b00};
  localparam logic [9:0] A_CTL  = {`PTC_IDX_CTL, 2'b00};
  localparam logic [9:0] A_TDR  = {`PTC_IDX_TDR, 2'b00};
  localparam logic [9:0] A_TSTS = {`PTC_IDX_TSTS, 2'b00};

  typedef struct packed {
    logic [15:0] d;
    logic        e;
    logic        rd;
  } ptc_note_s;

  logic        clk;
  logic        rst;
  logic        ce;
  logic [9:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  trig_out;
  logic [7:0]  trig_active;
  logic        clock_running;
  ptc_note_s   notes[$];
  ptc_note_s   nt;
  int          mismatches;
  int          tests_run;
  int          seed;
  logic [63:0] t0;
  logic [63:0] t1;
  logic [63:0] trg;

  ptc_ctrl i_dut (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .paddr         (paddr),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .trig_out      (trig_out),
    .trig_active   (trig_active),
    .clock_running (clock_running)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task results;
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  // ****************************************************************
  // APB master
  // ****************************************************************
  // Stall drops ce after setup, so pready stays low for that many edges
  task apb(input logic [9:0] a, input logic w, input logic [15:0] d,
           input logic [15:0] e, input logic er, input int stall);
    int n;
    notes.push_back('{d: e, e: er, rd: !w});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    if (stall > 0) begin
      ce <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == stall) begin
        ce <= 1'b1;
      end
    end while (pready !== 1'b1 && n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      results();
    end
  endtask

  task wr(input logic [9:0] a, input logic [15:0] d);
    apb(a, 1'b1, d, 16'h0000, 1'b0, 0);
  endtask

  task rd(input logic [9:0] a, input logic [15:0] e);
    apb(a, 1'b0, 16'h0000, e, 1'b0, 0);
  endtask

  task put4(input logic [63:0] v);
    for (int k = 0; k < 4; k++) begin
      apb(A_TDR, 1'b1, v[16*k +: 16], 16'h0000, 1'b0, (k == 0) ? 3 : 0);
    end
  endtask

  // Four words in write order, then zero past the end
  task get4(input logic [63:0] v);
    for (int k = 0; k < 4; k++) begin
      rd(A_TDR, v[16*k +: 16]);
    end
    rd(A_TDR, 16'h0000);
  endtask

  task flags(input logic run, input logic [7:0] act, input logic [7:0] outs);
    @(negedge clk);
    chk("clock_running", {15'h0000, run}, {15'h0000, clock_running});
    chk("trig_active", {8'h00, act}, {8'h00, trig_active});
    chk("trig_out", {8'h00, outs}, {8'h00, trig_out});
  endtask

  // ****************************************************************
  // Result monitor
  // ****************************************************************
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      nt = notes.pop_front();
      chk("pslverr", {15'h0000, nt.e}, {15'h0000, pslverr});
      if (nt.rd) begin
        chk("prdata", nt.d, prdata[15:0]);
        chk("prdata_hi", 16'h0000, prdata[31:16]);
      end
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    int n;
    seed = 62484;
    mismatches = 0;
    tests_run = 0;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h00000000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(A_CTL, 1'b0, 16'h0000, 16'h0000, 1'b1, 0);
    wr(A_PAGE, {13'h0000, `PTC_PAGE_PTP});
    rd(A_PAGE, 16'h0004);
    rd(A_CTL, `PTC_CTL_RESET);
    apb(10'h060, 1'b0, 16'h0000, 16'h0000, 1'b1, 0);
    wr(A_CTL, 16'hf400);
    rd(A_CTL, 16'h1400);
    wr(A_CTL, 16'h0004);
    rd(A_CTL, 16'h0004);
    wr(A_CTL, 16'h0000);
    flags(1'b1, 8'h00, 8'h00);
    wr(A_CTL, 16'h0002);
    rd(A_CTL, 16'h0000);
    flags(1'b0, 8'h00, 8'h00);
    wr(A_CTL, 16'h0004);
    wr(A_CTL, 16'h0006);
    flags(1'b0, 8'h00, 8'h00);
    // Offsets stay small so nanoseconds never carry into seconds
    t0 = {32'($random(seed)), 4'h0, 28'($random(seed))};
    t1 = {32'($random(seed)), 4'h0, 28'($random(seed))};
    put4(t0);
    wr(A_CTL, 16'h0010);
    wr(A_CTL, 16'h0020);
    get4(t0);
    put4(t1);
    wr(A_CTL, 16'h0008);
    wr(A_CTL, 16'h0020);
    get4(t0 + t1);
    // Top seconds word all ones so no trigger can fire here
    for (int i = 0; i < 8; i++) begin
      trg = {16'hffff, 16'($random(seed)), 32'($random(seed))};
      wr(A_CTL, {3'h0, 3'(i), 10'h040});
      rd(A_CTL, {3'h0, 3'(i), 10'h040});
      put4(trg);
      rd(A_CTL, {3'h0, 3'(i), 10'h000});
      wr(A_CTL, {3'h0, 3'(i), 10'h080});
      get4(trg);
    end
    wr(A_CTL, 16'h0d00);
    rd(A_CTL, 16'h0c00);
    flags(1'b0, 8'h08, 8'h00);
    rd(A_TSTS, 16'h0040);
    wr(A_CTL, 16'h0e00);
    rd(A_CTL, 16'h0c00);
    flags(1'b0, 8'h00, 8'h00);
    wr(A_CTL, 16'h0840);
    wr(A_TDR, 16'h1234);
    wr(A_TDR, 16'h5678);
    wr(A_CTL, 16'h0900);
    rd(A_CTL, 16'h0800);
    flags(1'b0, 8'h04, 8'h00);
    wr(A_CTL, 16'h0a00);
    put4(64'h0);
    wr(A_CTL, 16'h0010);
    wr(A_CTL, 16'h0020);
    get4(64'h0);
    wr(A_CTL, 16'h0040);
    put4(64'd400);
    wr(A_CTL, 16'h0100);
    wr(A_CTL, 16'h0004);
    for (n = 0; n < 200 && trig_out[0] !== 1'b1; n++) begin
      @(posedge clk);
    end
    if (n >= 200) begin
      mismatches++;
      results();
    end
    flags(1'b1, 8'h00, 8'h01);
    wr(A_CTL, 16'h0200);
    flags(1'b1, 8'h00, 8'h01);
    wr(A_CTL, 16'h1401);
    rd(A_CTL, 16'h0001);
    flags(1'b0, 8'h00, 8'h00);
    repeat (10) @(posedge clk);
    rd(A_CTL, 16'h0001);
    wr(A_CTL, 16'h0000);
    rd(A_CTL, 16'h0000);
    wr(A_CTL, 16'h0020);
    get4(64'h0);
    wr(A_PAGE, 16'h0000);
    apb(A_TDR, 1'b0, 16'h0000, 16'h0000, 1'b1, 0);
    apb(A_CTL, 1'b1, 16'h0004, 16'h0000, 1'b1, 0);
    flags(1'b0, 8'h00, 8'h00);
    results();
  end
endmodule
